// ===== rtl/ssr_regs.vh
// Purpose: Offsets, field positions, reset values and codes for the stream error status register slice.
// Assumes: A 12-bit word address on the register port, with 16-bit data words.
// Notes: Definitions only; this file has no logic.
`ifndef SSR_REGS_VH
`define SSR_REGS_VH

// Register word addresses.
`define SSR_ADDR_W 12
`define SSR_OFS_STREAM_TWO_PROCESSING_CONTROL 12'h001
`define SSR_OFS_STREAM_ONE_ERROR_STATUS 12'h002
`define SSR_OFS_STREAM_TWO_ERROR_STATUS 12'h003
`define SSR_OFS_RECEIVED_ERROR_PACKET_FLAGS 12'h004

// Processing control fields.
`define SSR_BIT_ANC_EXTRACT_STREAM_SELECT 7
`define SSR_BIT_STREAM2_BAD_WORD_FIX_OFF 4
`define SSR_BIT_STREAM2_CHECKSUM_INSERT_OFF 3
`define SSR_BIT_STREAM2_LINE_CHECK_INSERT_OFF 2
`define SSR_BIT_STREAM2_LINE_NUMBER_INSERT_OFF 1
`define SSR_BIT_STREAM2_TIMING_WORD_INSERT_OFF 0
`define SSR_CTRL_RESET 16'h0000
`define SSR_CTRL_WRITE_MASK 16'h009F

// Stream one and stream two error status fields.
`define SSR_BIT_VIDEO_STANDARD_MISMATCH 10
`define SSR_BIT_FULL_FIELD_CHECK_MISMATCH 9
`define SSR_BIT_ACTIVE_PICTURE_CHECK_MISMATCH 8
`define SSR_BIT_CHROMA_SUM_ERROR 6
`define SSR_BIT_LUMA_SUM_ERROR 5
`define SSR_BIT_CHROMA_LINE_CHECK_ERROR 4
`define SSR_BIT_LUMA_LINE_CHECK_ERROR 3
`define SSR_BIT_LINE_NUMBER_ERROR 2
`define SSR_BIT_ACTIVE_START_ERROR 1
`define SSR_BIT_ACTIVE_END_ERROR 0
`define SSR_STAT1_W 11
`define SSR_STAT2_W 7
`define SSR_STATUS_RESET 16'h0000

// Received error packet flag fields.
`define SSR_BIT_ERROR_PACKET_PRESENT 15
`define SSR_FLD_RX_ANCILLARY_HI 14
`define SSR_FLD_RX_ANCILLARY_LO 10
`define SSR_FLD_RX_FULL_FIELD_HI 9
`define SSR_FLD_RX_FULL_FIELD_LO 6
`define SSR_RX_FLAGS_RESET 16'h0000

// Input rate codes.
`define SSR_RATE_SD 2'h0
`define SSR_RATE_HD 2'h1
`define SSR_RATE_3G_A 2'h2
`define SSR_RATE_3G_B 2'h3

`endif

// ===== rtl/ssr_sticky.v
// Purpose: A bank of sticky error flags, set by event pulses and cleared as a group.
// Assumes: Set and clear come from logic on the same clock.
// Notes: A set in the clear cycle keeps its bit set.
`timescale 1ns/10ps

module ssr_sticky #(
  parameter WIDTH = 7
) (
  input wire clk, // Core clock.
  input wire srst, // Synchronous reset, active high.
  input wire ce, // Clock enable; state holds while low.
  input wire [WIDTH-1:0] set_vec, // One-cycle error events, one per bit.
  input wire clear, // Clears every bit of the bank not set in the same cycle.
  output wire [WIDTH-1:0] flags // Sticky flag levels.
);

  reg [WIDTH-1:0] flag_q;

  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
      always @(posedge clk) begin
        if (srst) begin
          flag_q[i] <= 1'b0;
        end else if (ce) begin
          if (set_vec[i]) begin
            flag_q[i] <= 1'b1;
          end else if (clear) begin
            flag_q[i] <= 1'b0;
          end
        end
      end
    end
  endgenerate

  assign flags = flag_q;

endmodule

// ===== rtl/ssr_regs_top.v
// Purpose: Host registers for stream two processing control, stream error status and received packet flags.
// Assumes: The host interface decoder presents word accesses on the same clock as the video core.
// Notes: Error inputs are one-cycle pulses; received flags are levels from the packet parser.
`timescale 1ns/10ps
`include "ssr_regs.vh"

// Contract
// - Control bit 7 picks the ancillary extraction stream, Level B only, reset 0.
// - Control bit 4 set stops stream two bad word remapping in Level B.
// - Control bit 3 set stops stream two checksum insertion in Level B.
// - Control bit 2 set stops stream two line check insertion in Level B.
// - Control bit 1 set stops stream two line number insertion in Level B.
// - Control bit 0 set stops stream two timing word insertion in Level B.
// - Status one bit 10 flags HD or SD standard mismatch; write clears.
// - Status one bits 9 and 8 flag full field and active picture mismatches.
// - Status one bits 6 and 5 flag stream one chroma and luma checksum errors.
// - Status one bits 4 and 3 flag stream one line check errors, not SD.
// - Status one bit 2 flags stream one line number errors, SD excluded.
// - Status one bits 1 and 0 flag stream one active start and end errors.
// - Status two bits 6 and 5 flag stream two checksum errors; 15 to 7 reserved.
// - Status two bits 4 to 0 flag stream two line check, number, start, end errors.
// - Flags bit 15 shows packet present; bits 14 to 10 ancillary flags.
// - Flags bits 9 to 6 show the received full field flags.
module ssr_regs_top (
  input wire clk, // Core clock, 25 MHz.
  input wire srst, // Synchronous reset, active high.
  input wire ce, // Clock enable; all state holds while low.
  input wire [`SSR_ADDR_W-1:0] reg_addr, // Register word address.
  input wire reg_wr, // Write strobe, one cycle.
  input wire reg_rd, // Read strobe, one cycle.
  input wire [15:0] reg_wdata, // Write data.
  output reg [15:0] reg_rdata, // Read data, valid with reg_rd_valid.
  output reg reg_rd_valid, // Read answer pulse.
  output reg reg_wr_ack, // Write taken pulse.
  input wire [1:0] rate_mode, // Input rate: SD, HD, 3G Level A, 3G Level B.
  input wire video_standard_mismatch, // Standard mismatch event.
  input wire full_field_check_mismatch, // Packet full field mismatch event.
  input wire active_picture_check_mismatch, // Packet active picture mismatch event.
  input wire stream1_chroma_sum_error, // Stream one chroma checksum event.
  input wire stream1_luma_sum_error, // Stream one luma checksum event.
  input wire stream1_chroma_line_check_error, // Stream one chroma line check event.
  input wire stream1_luma_line_check_error, // Stream one luma line check event.
  input wire stream1_line_number_error, // Stream one line number event.
  input wire stream1_active_start_error, // Stream one active start event.
  input wire stream1_active_end_error, // Stream one active end event.
  input wire stream2_chroma_sum_error, // Stream two chroma checksum event.
  input wire stream2_luma_sum_error, // Stream two luma checksum event.
  input wire stream2_chroma_line_check_error, // Stream two chroma line check event.
  input wire stream2_luma_line_check_error, // Stream two luma line check event.
  input wire stream2_line_number_error, // Stream two line number event.
  input wire stream2_active_start_error, // Stream two active start event.
  input wire stream2_active_end_error, // Stream two active end event.
  input wire error_packet_present, // Packet found in the input, level.
  input wire [4:0] rx_ancillary_flags, // Unknown, internal already, internal here, already, here.
  input wire [3:0] rx_full_field_flags, // Unknown, internal already, internal here, already.
  output reg ancillary_extract_stream_select, // Extract from stream two when high.
  output reg stream2_bad_word_fix_off, // Stop stream two word remapping.
  output reg stream2_checksum_insert_off, // Stop stream two checksum insertion.
  output reg stream2_line_check_insert_off, // Stop stream two line check insertion.
  output reg stream2_line_number_insert_off, // Stop stream two line number insertion.
  output reg stream2_timing_word_insert_off // Stop stream two timing word insertion.
);

  reg [15:0] stream_two_processing_control;
  reg [15:0] received_error_packet_flags;
  reg [15:0] next_rdata;
  reg [`SSR_STAT1_W-1:0] stat1_set;
  reg [`SSR_STAT2_W-1:0] stat2_set;

  // Gated control levels, one cycle ahead of their output registers.
  reg next_ancillary_extract_stream_select;
  reg next_stream2_bad_word_fix_off;
  reg next_stream2_checksum_insert_off;
  reg next_stream2_line_check_insert_off;
  reg next_stream2_line_number_insert_off;
  reg next_stream2_timing_word_insert_off;

  wire [`SSR_STAT1_W-1:0] stat1_flags;
  wire [`SSR_STAT2_W-1:0] stat2_flags;
  wire [15:0] stream_one_error_status;
  wire [15:0] stream_two_error_status;
  wire hit_ctrl;
  wire hit_stat1;
  wire hit_stat2;
  wire level_b;
  wire not_sd;
  wire hd_or_sd;
  // Clear strobes for the two status banks.
  wire clear_stat1;
  wire clear_stat2;
  // Named views of the received flag inputs.
  wire rx_ancillary_unknown_status;
  wire rx_ancillary_internal_already;
  wire rx_ancillary_internal_here;
  wire rx_ancillary_error_already;
  wire rx_ancillary_error_here;
  wire rx_full_field_unknown_status;
  wire rx_full_field_internal_already;
  wire rx_full_field_internal_here;
  wire rx_full_field_error_already;

  assign hit_ctrl = (reg_addr == `SSR_OFS_STREAM_TWO_PROCESSING_CONTROL);
  assign hit_stat1 = (reg_addr == `SSR_OFS_STREAM_ONE_ERROR_STATUS);
  assign hit_stat2 = (reg_addr == `SSR_OFS_STREAM_TWO_ERROR_STATUS);
  assign level_b = (rate_mode == `SSR_RATE_3G_B);
  assign not_sd = (rate_mode != `SSR_RATE_SD);
  assign hd_or_sd = (rate_mode == `SSR_RATE_SD) || (rate_mode == `SSR_RATE_HD);

  // A status write clears every bit not set by an event in the same cycle, whatever data it carries.
  assign clear_stat1 = reg_wr & hit_stat1;
  assign clear_stat2 = reg_wr & hit_stat2;

  // Received packet flags, named one by one in register order.
  // The parser drives them as levels, so no edge logic sits between them and the register.
  // ancillary and full field flags.
  assign rx_ancillary_unknown_status = rx_ancillary_flags[4];
  assign rx_ancillary_internal_already = rx_ancillary_flags[3];
  assign rx_ancillary_internal_here = rx_ancillary_flags[2];
  assign rx_ancillary_error_already = rx_ancillary_flags[1];
  assign rx_ancillary_error_here = rx_ancillary_flags[0];
  assign rx_full_field_unknown_status = rx_full_field_flags[3];
  assign rx_full_field_internal_already = rx_full_field_flags[2];
  assign rx_full_field_internal_here = rx_full_field_flags[1];
  assign rx_full_field_error_already = rx_full_field_flags[0];

  // Control register: only the implemented fields store; others read zero.
  always @(posedge clk) begin
    if (srst) begin
      stream_two_processing_control <= `SSR_CTRL_RESET;
    end else if (ce && reg_wr && hit_ctrl) begin
      stream_two_processing_control <= reg_wdata & `SSR_CTRL_WRITE_MASK;
    end
  end

  // Stream controls act only while the input is 3G Level B.
  always @* begin
    next_ancillary_extract_stream_select = level_b &
      stream_two_processing_control[`SSR_BIT_ANC_EXTRACT_STREAM_SELECT];
    next_stream2_bad_word_fix_off = level_b &
      stream_two_processing_control[`SSR_BIT_STREAM2_BAD_WORD_FIX_OFF];
    next_stream2_checksum_insert_off = level_b &
      stream_two_processing_control[`SSR_BIT_STREAM2_CHECKSUM_INSERT_OFF];
    next_stream2_line_check_insert_off = level_b &
      stream_two_processing_control[`SSR_BIT_STREAM2_LINE_CHECK_INSERT_OFF];
    next_stream2_line_number_insert_off = level_b &
      stream_two_processing_control[`SSR_BIT_STREAM2_LINE_NUMBER_INSERT_OFF];
    next_stream2_timing_word_insert_off = level_b &
      stream_two_processing_control[`SSR_BIT_STREAM2_TIMING_WORD_INSERT_OFF];
  end

  // Registering the gated levels keeps a rate change from glitching the core controls.
  always @(posedge clk) begin
    if (srst) begin
      ancillary_extract_stream_select <= 1'b0;
      stream2_bad_word_fix_off <= 1'b0;
      stream2_checksum_insert_off <= 1'b0;
      stream2_line_check_insert_off <= 1'b0;
      stream2_line_number_insert_off <= 1'b0;
      stream2_timing_word_insert_off <= 1'b0;
    end else if (ce) begin
      ancillary_extract_stream_select <= next_ancillary_extract_stream_select;
      stream2_bad_word_fix_off <= next_stream2_bad_word_fix_off;
      stream2_checksum_insert_off <= next_stream2_checksum_insert_off;
      stream2_line_check_insert_off <= next_stream2_line_check_insert_off;
      stream2_line_number_insert_off <= next_stream2_line_number_insert_off;
      stream2_timing_word_insert_off <= next_stream2_timing_word_insert_off;
    end
  end

  // Standard, line check, line number and stream two events are qualified by the input rate before they reach the sticky bits.
  always @* begin
    stat1_set = {`SSR_STAT1_W{1'b0}};
    // standard mismatch for HD and SD.
    stat1_set[`SSR_BIT_VIDEO_STANDARD_MISMATCH] = video_standard_mismatch & hd_or_sd;
    stat1_set[`SSR_BIT_FULL_FIELD_CHECK_MISMATCH] = full_field_check_mismatch;
    stat1_set[`SSR_BIT_ACTIVE_PICTURE_CHECK_MISMATCH] = active_picture_check_mismatch;
    stat1_set[`SSR_BIT_CHROMA_SUM_ERROR] = stream1_chroma_sum_error;
    stat1_set[`SSR_BIT_LUMA_SUM_ERROR] = stream1_luma_sum_error;
    stat1_set[`SSR_BIT_CHROMA_LINE_CHECK_ERROR] = stream1_chroma_line_check_error & not_sd;
    stat1_set[`SSR_BIT_LUMA_LINE_CHECK_ERROR] = stream1_luma_line_check_error & not_sd;
    stat1_set[`SSR_BIT_LINE_NUMBER_ERROR] = stream1_line_number_error & not_sd;
    stat1_set[`SSR_BIT_ACTIVE_START_ERROR] = stream1_active_start_error;
    stat1_set[`SSR_BIT_ACTIVE_END_ERROR] = stream1_active_end_error;
  end

  always @* begin
    stat2_set = {`SSR_STAT2_W{1'b0}};
    stat2_set[`SSR_BIT_CHROMA_SUM_ERROR] = stream2_chroma_sum_error & level_b;
    stat2_set[`SSR_BIT_LUMA_SUM_ERROR] = stream2_luma_sum_error & level_b;
    // stream two line and timing errors.
    stat2_set[`SSR_BIT_CHROMA_LINE_CHECK_ERROR] = stream2_chroma_line_check_error & level_b;
    stat2_set[`SSR_BIT_LUMA_LINE_CHECK_ERROR] = stream2_luma_line_check_error & level_b;
    stat2_set[`SSR_BIT_LINE_NUMBER_ERROR] = stream2_line_number_error & level_b;
    stat2_set[`SSR_BIT_ACTIVE_START_ERROR] = stream2_active_start_error & level_b;
    stat2_set[`SSR_BIT_ACTIVE_END_ERROR] = stream2_active_end_error & level_b;
  end

  ssr_sticky #(
    .WIDTH(`SSR_STAT1_W)
  ) u_stat1 (
    .clk(clk),
    .srst(srst),
    .ce(ce),
    .set_vec(stat1_set),
    .clear(clear_stat1),
    .flags(stat1_flags)
  );

  ssr_sticky #(
    .WIDTH(`SSR_STAT2_W)
  ) u_stat2 (
    .clk(clk),
    .srst(srst),
    .ce(ce),
    .set_vec(stat2_set),
    .clear(clear_stat2),
    .flags(stat2_flags)
  );

  // Reserved status bits read zero.
  assign stream_one_error_status = {5'h00, stat1_flags};
  assign stream_two_error_status = {9'h000, stat2_flags};

  // Received flags are sampled each cycle; bits 5 to 0 belong elsewhere and read zero.
  always @(posedge clk) begin
    if (srst) begin
      received_error_packet_flags <= `SSR_RX_FLAGS_RESET;
    end else if (ce) begin
      received_error_packet_flags[`SSR_BIT_ERROR_PACKET_PRESENT] <= error_packet_present;
      // Field order follows the register, most significant flag first.
      received_error_packet_flags[`SSR_FLD_RX_ANCILLARY_HI:`SSR_FLD_RX_ANCILLARY_LO] <= {
        rx_ancillary_unknown_status,
        rx_ancillary_internal_already,
        rx_ancillary_internal_here,
        rx_ancillary_error_already,
        rx_ancillary_error_here
      };
      received_error_packet_flags[`SSR_FLD_RX_FULL_FIELD_HI:`SSR_FLD_RX_FULL_FIELD_LO] <= {
        rx_full_field_unknown_status,
        rx_full_field_internal_already,
        rx_full_field_internal_here,
        rx_full_field_error_already
      };
      received_error_packet_flags[5:0] <= 6'h00;
    end
  end

  // Unmapped addresses read zero, so software never sees stale data there.
  always @* begin
    case (reg_addr)
      `SSR_OFS_STREAM_TWO_PROCESSING_CONTROL: begin
        next_rdata = stream_two_processing_control;
      end
      `SSR_OFS_STREAM_ONE_ERROR_STATUS: begin
        next_rdata = stream_one_error_status;
      end
      `SSR_OFS_STREAM_TWO_ERROR_STATUS: begin
        next_rdata = stream_two_error_status;
      end
      `SSR_OFS_RECEIVED_ERROR_PACKET_FLAGS: begin
        next_rdata = received_error_packet_flags;
      end
      default: begin
        next_rdata = 16'h0000;
      end
    endcase
  end

  // Read data and answer pulses are registered one cycle after the strobe.
  always @(posedge clk) begin
    if (srst) begin
      reg_rdata <= 16'h0000;
      reg_rd_valid <= 1'b0;
      reg_wr_ack <= 1'b0;
    end else if (ce) begin
      reg_rd_valid <= reg_rd;
      reg_wr_ack <= reg_wr;
      if (reg_rd) begin
        reg_rdata <= next_rdata;
      end
    end
  end

endmodule

// ===== dv/ssr_regs_chk.sv
// Purpose: Concurrent checks on the stream error status register slice ports.
// Assumes: One clock domain; requests are taken only on edges with ce high.
// Notes: Bound to ssr_regs_top from the testbench top file.
`timescale 1ns/10ps

module ssr_regs_chk (
  input wire clk, // Clock.
  input wire srst, // Reset.
  input wire ce, // Enable.
  input wire [11:0] reg_addr, // Address.
  input wire reg_wr, // Write strobe.
  input wire reg_rd, // Read strobe.
  input wire [15:0] reg_wdata, // Write data.
  input wire [15:0] reg_rdata, // Read data.
  input wire [1:0] rate_mode, // Input rate.
  input wire stream1_active_end_error, // Event.
  input wire error_packet_present, // Level.
  input wire [4:0] rx_ancillary_flags, // Levels.
  input wire [3:0] rx_full_field_flags, // Levels.
  input wire ancillary_extract_stream_select, // Output.
  input wire stream2_bad_word_fix_off, // Output.
  input wire stream2_timing_word_insert_off // Output.
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  property p_sel_gate;
    ce && rate_mode != 2'h3 |=> !ancillary_extract_stream_select;
  endproperty
  a_sel_gate: assert property (p_sel_gate) else $error("select high outside level B");
  property p_fix_follow;
    ce && rate_mode == 2'h3 && reg_wr && reg_addr == 12'h001 ##1 ce && rate_mode == 2'h3
      |=> stream2_bad_word_fix_off == |($past(reg_wdata, 2) & 16'h0010);
  endproperty
  a_fix_follow: assert property (p_fix_follow) else $error("remap mask output wrong");
  property p_trs_gate;
    ce && rate_mode != 2'h3 |=> !stream2_timing_word_insert_off;
  endproperty
  a_trs_gate: assert property (p_trs_gate) else $error("timing word mask high outside level B");
  property p_ctrl_readback;
    ce && reg_wr && reg_addr == 12'h001 ##1 !reg_wr ##1 ce && reg_rd && reg_addr == 12'h001
      |=> reg_rdata == ($past(reg_wdata, 3) & 16'h009F);
  endproperty
  a_ctrl_readback: assert property (p_ctrl_readback) else $error("control readback wrong");
  property p_s1_sticky;
    ce && stream1_active_end_error ##1 ce && reg_rd && reg_addr == 12'h002 |=> reg_rdata[0];
  endproperty
  a_s1_sticky: assert property (p_s1_sticky) else $error("end error not flagged");
  property p_s2_gate;
    ce && reg_wr && reg_addr == 12'h003 && rate_mode != 2'h3 ##1 ce && rate_mode != 2'h3 ##1
      ce && reg_rd && reg_addr == 12'h003 |=> reg_rdata == 16'h0000;
  endproperty
  a_s2_gate: assert property (p_s2_gate) else $error("stream two status set outside level B");
  property p_s2_reserved;
    ce && reg_rd && reg_addr == 12'h003 |=> reg_rdata[15:7] == 9'h000;
  endproperty
  a_s2_reserved: assert property (p_s2_reserved) else $error("reserved status bits set");
  property p_flags;
    ce ##1 ce && reg_rd && reg_addr == 12'h004 |=> reg_rdata == {$past(error_packet_present, 2),
      $past(rx_ancillary_flags, 2), $past(rx_full_field_flags, 2), 6'h00};
  endproperty
  a_flags: assert property (p_flags) else $error("received flags readback wrong");
endmodule

// ===== dv/tb_sdi_stream_error_status_regs.sv
// Purpose: Self-checking bench for the stream error status register slice.
// Assumes: Word accesses on the core clock; inputs move 1 ns after the edge.
// Notes: Each access task leaves an idle cycle so strobes never toggle twice at once.
`timescale 1ns/10ps

module tb_sdi_stream_error_status_regs;
  reg clk, srst, ce, reg_wr, reg_rd, present;
  reg [11:0] reg_addr;
  reg [15:0] reg_wdata;
  reg [1:0] rate_mode;
  reg [10:0] ev1;
  reg [6:0] ev2;
  reg [4:0] anc;
  reg [3:0] ffl;
  wire [15:0] reg_rdata;
  wire reg_rd_valid, reg_wr_ack;
  wire [5:0] outs;
  integer num_errors, comparisons, i;
  ssr_regs_top u_ssr_regs_top (.clk(clk), .srst(srst), .ce(ce), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rd_valid(reg_rd_valid),
    .reg_wr_ack(reg_wr_ack), .rate_mode(rate_mode), .video_standard_mismatch(ev1[10]),
    .full_field_check_mismatch(ev1[9]), .active_picture_check_mismatch(ev1[8]), .stream1_chroma_sum_error(ev1[6]),
    .stream1_luma_sum_error(ev1[5]), .stream1_chroma_line_check_error(ev1[4]),
    .stream1_luma_line_check_error(ev1[3]), .stream1_line_number_error(ev1[2]),
    .stream1_active_start_error(ev1[1]), .stream1_active_end_error(ev1[0]), .stream2_chroma_sum_error(ev2[6]),
    .stream2_luma_sum_error(ev2[5]), .stream2_chroma_line_check_error(ev2[4]),
    .stream2_luma_line_check_error(ev2[3]), .stream2_line_number_error(ev2[2]),
    .stream2_active_start_error(ev2[1]), .stream2_active_end_error(ev2[0]), .error_packet_present(present),
    .rx_ancillary_flags(anc), .rx_full_field_flags(ffl), .ancillary_extract_stream_select(outs[5]),
    .stream2_bad_word_fix_off(outs[4]), .stream2_checksum_insert_off(outs[3]),
    .stream2_line_check_insert_off(outs[2]), .stream2_line_number_insert_off(outs[1]),
    .stream2_timing_word_insert_off(outs[0]));
  task cmp(input [15:0] got, input [15:0] exp);
    begin
      comparisons = comparisons + 1;
      if (got !== exp) begin
        num_errors = num_errors + 1;
        $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  task tick;
    begin
      @(posedge clk);
      #1;
    end
  endtask
  task wr(input [11:0] a, input [15:0] d);
    begin
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      tick;
      reg_wr = 1'b0;
      cmp({15'h0000, reg_wr_ack}, 16'h0001);
      tick;
    end
  endtask
  task rd(input [11:0] a, input [15:0] e);
    begin
      reg_addr = a;
      reg_rd = 1'b1;
      tick;
      reg_rd = 1'b0;
      cmp({15'h0000, reg_rd_valid}, 16'h0001);
      cmp(reg_rdata, e);
      tick;
    end
  endtask
  task pulse(input [10:0] a, input [6:0] b);
    begin
      ev1 = a;
      ev2 = b;
      tick;
      ev1 = 11'h000;
      ev2 = 7'h00;
    end
  endtask
  task t_reset_vals;
    begin
      rd(12'h001, 16'h0000);
      rd(12'h002, 16'h0000);
      rd(12'h003, 16'h0000);
      rd(12'hABC, 16'h0000);
      wr(12'h004, 16'hFFFF);
      rd(12'h004, 16'h0000);
    end
  endtask
  task t_control;
    begin
      rate_mode = 2'h3;
      wr(12'h001, 16'hFFFF);
      rd(12'h001, 16'h009F);
      for (i = 0; i < 6; i = i + 1) begin
        wr(12'h001, (i == 5) ? 16'h0080 : (16'h0001 << i));
        cmp({10'h000, outs}, 16'h0001 << i);
      end
      wr(12'h001, 16'hFFFF);
      cmp({10'h000, outs}, 16'h003F);
      rate_mode = 2'h2;
      tick;
      cmp({10'h000, outs}, 16'h0000);
    end
  endtask
  task t_status;
    begin
      for (i = 0; i < 4; i = i + 1) begin
        rate_mode = i[1:0];
        wr(12'h002, 16'hFFFF);
        wr(12'h003, 16'h0000);
        pulse(11'h7FF, 7'h7F);
        tick;
        rd(12'h002, (i == 0) ? 16'h0763 : (i == 1) ? 16'h077F : 16'h037F);
        rd(12'h003, (i == 3) ? 16'h007F : 16'h0000);
        wr(12'h003, 16'h0000);
        rd(12'h003, 16'h0000);
      end
      rate_mode = 2'h1;
      for (i = 0; i < 11; i = i + 1) begin
        wr(12'h002, 16'h0000);
        pulse(11'h001 << i, 7'h00);
        rd(12'h002, (i == 7) ? 16'h0000 : (16'h0001 << i));
      end
      rate_mode = 2'h3;
      for (i = 0; i < 7; i = i + 1) begin
        wr(12'h003, 16'h0000);
        pulse(11'h000, 7'h01 << i);
        rd(12'h003, 16'h0001 << i);
      end
      ev1 = 11'h001;
      reg_addr = 12'h002;
      reg_wr = 1'b1;
      tick;
      ev1 = 11'h000;
      reg_wr = 1'b0;
      tick;
      rd(12'h002, 16'h0001);
    end
  endtask
  task t_flags;
    begin
      present = 1'b1;
      anc = 5'h15;
      ffl = 4'hA;
      tick;
      rd(12'h004, 16'hD680);
      present = 1'b0;
      anc = 5'h0A;
      ffl = 4'h5;
      tick;
      rd(12'h004, 16'h2940);
    end
  endtask
  task t_freeze;
    begin
      wr(12'h002, 16'h0000);
      ce = 1'b0;
      reg_addr = 12'h001;
      reg_wdata = 16'h0000;
      reg_wr = 1'b1;
      pulse(11'h7FF, 7'h7F);
      reg_wr = 1'b0;
      tick;
      cmp({15'h0000, reg_wr_ack}, 16'h0000);
      ce = 1'b1;
      rd(12'h001, 16'h009F);
      rd(12'h002, 16'h0000);
      rd(12'h003, 16'h0040);
    end
  endtask
  task t_reset_again;
    begin
      srst = 1'b1;
      tick;
      srst = 1'b0;
      cmp({10'h000, outs}, 16'h0000);
      rd(12'h001, 16'h0000);
      rd(12'h003, 16'h0000);
    end
  endtask
  task tally_and_finish;
    begin
      if (num_errors == 0 && comparisons > 0) begin
        $display("No errors found");
      end else begin
        $display("Errors were found");
      end
      $finish;
    end
  endtask
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial begin
    #(40 * 5000);
    num_errors = num_errors + 1;
    tally_and_finish;
  end
  initial begin
    num_errors = 0;
    comparisons = 0;
    {srst, ce, reg_wr, reg_rd, present} = 5'b11000;
    {reg_addr, reg_wdata, rate_mode, ev1, ev2, anc, ffl} = 0;
    repeat (8) @(posedge clk);
    #1;
    srst = 1'b0;
    t_reset_vals;
    t_control;
    t_status;
    t_flags;
    t_freeze;
    t_reset_again;
    tally_and_finish;
  end
endmodule

bind ssr_regs_top ssr_regs_chk u_ssr_regs_chk (.clk(clk), .srst(srst), .ce(ce), .reg_addr(reg_addr),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .rate_mode(rate_mode),
  .stream1_active_end_error(stream1_active_end_error), .error_packet_present(error_packet_present),
  .rx_ancillary_flags(rx_ancillary_flags), .rx_full_field_flags(rx_full_field_flags),
  .ancillary_extract_stream_select(ancillary_extract_stream_select),
  .stream2_bad_word_fix_off(stream2_bad_word_fix_off),
  .stream2_timing_word_insert_off(stream2_timing_word_insert_off));
